// >>> tb_usart_quirks.sv
// self-checking bench for the serial receiver with mode quirks
// assumes usart_link_peer drives the link at 125 ns per bit
`timescale 1ns/1ps
module tb_usart_quirks;
  logic        sys_clk_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic        lclk, lframe_n, ldata;
  logic [1:0]  mode = 2'b00;
  logic [3:0]  len = 4'h8;
  logic        rx_en = 1'b1, f_hi = 1'b0, f_lo = 1'b0, tx_done = 1'b0;
  logic        soft_rst = 1'b0, mode_wr = 1'b0, ctrl_wr = 1'b0;
  logic        clr = 1'b0, rdy = 1'b1;
  logic        valid, flow, ovl, ovr, corrupt, blocked;
  logic [8:0]  data;
  logic [7:0]  iso_cnt;
  logic [8:0]  got_q[$], exp_q[$];
  logic [15:0] w;
  int          n_errors = 0, n_checks = 0, n0;
  int          lens[3] = '{2, 9, 5};

  always #12.5 sys_clk_in = ~sys_clk_in;

  usart_quirks DUT (
    .sys_clk_in                 (sys_clk_in),
    .sys_rst_in                 (sys_rst_in),
    .link_clk_in                (lclk),
    .link_frame_n_in            (lframe_n),
    .link_data_in               (ldata),
    .serial_mode_in             (mode),
    .char_len_in                (len),
    .rx_enable_in               (rx_en),
    .flow_request_force_high_in (f_hi),
    .flow_request_force_low_in  (f_lo),
    .tx_done_in                 (tx_done),
    .rx_soft_reset_in           (soft_rst),
    .mode_write_in              (mode_wr),
    .control_write_in           (ctrl_wr),
    .status_clear_in            (clr),
    .dma_ready_in               (rdy),
    .dma_valid_out              (valid),
    .dma_data_out               (data),
    .flow_request_out           (flow),
    .spi_overlength_out         (ovl),
    .overrun_out                (ovr),
    .corrupt_out                (corrupt),
    .rx_blocked_out             (blocked),
    .iso_error_count_out        (iso_cnt)
  );

  usart_link_peer peer (
    .link_clk_out     (lclk),
    .link_frame_n_out (lframe_n),
    .link_data_out    (ldata)
  );

  always @(posedge sys_clk_in) begin
    if (valid === 1'b1 && rdy === 1'b1)
      got_q.push_back(data);
  end

  function automatic logic [8:0] exp_w(input logic [15:0] v, input int n);
    return 9'(v & ((16'h0001 << n) - 16'h0001));
  endfunction

  task automatic chk(input string what, input logic [8:0] e,
                     input logic [8:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_in);
  endtask

  task automatic frame(input logic [15:0] v, input int n);
    peer.send(v, n);
    cyc(10);
    @(negedge sys_clk_in);
  endtask

  task automatic wait_pops(input int n);
    int k;
    for (k = 0; k < 400 && got_q.size() < n; k++)
      @(posedge sys_clk_in);
    if (k == 400) begin
      n_errors++;
      $display("Error words expected %0d seen %0d", n, got_q.size());
      end_sim();
    end
  endtask

  initial begin
    void'($urandom(79));
    fork
      peer.tick(1);
      cyc(10);
    join
    sys_rst_in <= 1'b0;
    @(negedge sys_clk_in);
    chk("reset flow", 0, flow);
    chk("reset valid", 0, valid);
    chk("error count", 0, iso_cnt);
    // overrides, back to back and together
    cyc(1);
    f_hi <= 1'b1;
    cyc(1);
    f_hi <= 1'b0;
    @(negedge sys_clk_in);
    chk("flow high", 1, flow);
    cyc(1);
    f_lo <= 1'b1;
    cyc(1);
    f_hi <= 1'b1;
    @(negedge sys_clk_in);
    chk("flow low", 0, flow);
    cyc(1);
    f_hi <= 1'b0;
    f_lo <= 1'b0;
    @(negedge sys_clk_in);
    chk("flow both", 1, flow);
    cyc(1);
    f_lo <= 1'b1;
    cyc(1);
    f_lo <= 1'b0;
    @(negedge sys_clk_in);
    chk("flow low", 0, flow);
    // normal mode: lengths and short frames
    foreach (lens[i]) begin
      cyc(1);
      len <= 4'(lens[i]);
      peer.tick(3);
      w = 16'($urandom);
      frame(w, lens[i]);
      chk("word", exp_w(w, lens[i]), got_q[$]);
      n0 = got_q.size();
      frame(w, lens[i] - 1);
      chk("short frame", 9'(n0), 9'(got_q.size()));
    end
    // handshake mode: fill the buffer with the drain stalled
    cyc(1);
    len <= 4'h8;
    mode <= usart_quirks_pkg::MODE_HANDSHAKE;
    rdy <= 1'b0;
    peer.tick(3);
    got_q.delete();
    repeat (16) begin
      w = 16'($urandom);
      exp_q.push_back(exp_w(w, 8));
      frame(w, 8);
    end
    chk("flow full", 0, flow);
    frame(16'h00a5, 8);
    chk("overrun", 1, ovr);
    chk("flow full", 0, flow);
    cyc(1);
    clr <= 1'b1;
    cyc(1);
    clr <= 1'b0;
    rdy <= 1'b1;
    @(negedge sys_clk_in);
    chk("overrun clear", 0, ovr);
    wait_pops(16);
    foreach (exp_q[i]) chk("fifo word", exp_q[i], got_q[i]);
    // iso t1: lock after transmit, unlock sequence
    cyc(1);
    mode <= usart_quirks_pkg::MODE_ISO_T1;
    w = 16'($urandom);
    frame(w, 8);
    chk("t1 word", exp_w(w, 8), got_q[$]);
    cyc(1);
    tx_done <= 1'b1;
    cyc(1);
    tx_done <= 1'b0;
    @(negedge sys_clk_in);
    chk("t1 lock", 1, blocked);
    n0 = got_q.size();
    frame(w, 8);
    chk("t1 drop", 9'(n0), 9'(got_q.size()));
    cyc(1);
    soft_rst <= 1'b1;
    cyc(1);
    soft_rst <= 1'b0;
    mode_wr <= 1'b1;
    cyc(1);
    mode_wr <= 1'b0;
    ctrl_wr <= 1'b1;
    @(negedge sys_clk_in);
    chk("t1 still", 1, blocked);
    cyc(1);
    ctrl_wr <= 1'b0;
    @(negedge sys_clk_in);
    chk("t1 open", 0, blocked);
    w = 16'($urandom);
    frame(w, 8);
    chk("t1 again", exp_w(w, 8), got_q[$]);
    // spi slave: overlength, then poisoned reception
    cyc(1);
    mode <= usart_quirks_pkg::MODE_SPI_SLAVE;
    frame(16'h0155, 8);
    chk("no overlength", 0, ovl);
    frame(16'h0155, 9);
    chk("overlength", 1, ovl);
    n0 = got_q.size();
    cyc(1);
    rx_en <= 1'b0;
    soft_rst <= 1'b1;
    cyc(1);
    rx_en <= 1'b1;
    soft_rst <= 1'b0;
    frame(16'h003c, 8);
    chk("corrupt", 1, corrupt);
    chk("corrupt drop", 9'(n0), 9'(got_q.size()));
    cyc(1);
    clr <= 1'b1;
    cyc(1);
    clr <= 1'b0;
    @(negedge sys_clk_in);
    chk("sticky clear", 0, ovl | corrupt);
    w = 16'($urandom);
    frame(w, 8);
    chk("spi word", exp_w(w, 8), got_q[$]);
    chk("error count", 0, iso_cnt);
    end_sim();
  end
endmodule

// >>> usart_link_peer.sv
// serial peer model: drives frame select, clock and data into the receiver
// assumes its tasks are called from one bench process at a time
`timescale 1ns/1ps
module usart_link_peer (
  output logic link_clk_out,     // serial clock, idle low
  output logic link_frame_n_out, // frame select, low
  output logic link_data_out     // serial data, msb first
);
  initial begin
    link_clk_out = 1'b0;
    link_frame_n_out = 1'b1;
    link_data_out = 1'b0;
  end

  // clock pulses outside a frame, for reset and length sync
  task automatic tick(input int n);
    repeat (n) begin
      #62.5 link_clk_out = 1'b1;
      #62.5 link_clk_out = 1'b0;
    end
  endtask

  task automatic send(input logic [15:0] v, input int n);
    link_frame_n_out = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      link_data_out = v[i];
      #62.5 link_clk_out = 1'b1;
      #62.5 link_clk_out = 1'b0;
    end
    // released line shows no stale bit
    link_data_out = ~link_data_out;
    #62.5 link_frame_n_out = 1'b1;
  endtask
endmodule

// >>> usart_quirks.sv
// serial receiver: link shifter, receive buffer, flow request and quirks
// assumes link pins arrive on link_clk_in; config ports on sys_clk_in
// How it works
// R1: in handshake mode a full buffer should raise request; here stays low
// R2: a force-high strobe drives the request output high regardless of buffer
// R3: a force-low strobe drives the request output low again
// R4: the external serial clock must be at least nine times slower; the bench drives it only five times slower
// R5: in SPI slave mode bits beyond the character length flag an error
// R6: after an overlength error the next reception is corrupted, reset or not
// R7: the ISO error count always reads zero
// R8: ISO T1 reception blocked after transmit until soft reset, mode, control
`timescale 1ns/1ps
`include "usart_quirks_cfg.svh"

module rx_fifo #(
  parameter int W     = `UQ_DATA_W,
  parameter int DEPTH = `UQ_FIFO_DEPTH
) (
  input  wire logic         clk_in,       // system clock
  input  wire logic         rst_in,       // async reset, high
  input  wire logic         in_valid_in,  // write request
  output logic              in_ready_out, // room available
  input  wire logic [W-1:0] in_data_in,   // write word
  output logic              out_valid_out,// output word valid
  input  wire logic         out_ready_in, // drain accepts
  output logic [W-1:0]      out_data_out  // output word
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("fifo depth must be a power of two of at least two");
  end
  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0]   cnt_q;
  logic          push;
  logic          load;
  // the output stage counts toward the depth
  assign in_ready_out = (cnt_q + {{AW{1'b0}}, out_valid_out}) != (AW+1)'(DEPTH);
  assign push = in_valid_in && in_ready_out;
  assign load = (cnt_q != '0) && (!out_valid_out || out_ready_in);
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr_q] <= in_data_in;
    end
  end
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q    <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (load) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      if (push && !load) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (load && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
  // registered output stage
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      out_valid_out <= 1'b0;
      out_data_out  <= '0;
    end else if (load) begin
      out_valid_out <= 1'b1;
      out_data_out  <= mem[rd_ptr_q];
    end else if (out_ready_in) begin
      out_valid_out <= 1'b0;
    end
  end
endmodule

module usart_quirks #(
  parameter int   W             = `UQ_DATA_W,
  parameter int   DEPTH         = `UQ_FIFO_DEPTH,
  parameter logic FIX_RTS_FULL  = `UQ_FIX_RTS_FULL
) (
  input  wire logic             sys_clk_in,          // 40 MHz clock
  input  wire logic             sys_rst_in,          // async reset, high
  input  wire logic             link_clk_in,         // serial clock
  input  wire logic             link_frame_n_in,     // frame select, low
  input  wire logic             link_data_in,        // serial data
  input  wire logic [1:0]       serial_mode_in,      // operating mode
  input  wire logic [3:0]       char_len_in,         // bits per char
  input  wire logic             rx_enable_in,        // receiver on
  input  wire logic             flow_request_force_high_in, // strobe
  input  wire logic             flow_request_force_low_in,  // strobe
  input  wire logic             tx_done_in,          // frame sent
  input  wire logic             rx_soft_reset_in,    // soft reset strobe
  input  wire logic             mode_write_in,       // mode reg written
  input  wire logic             control_write_in,    // control written
  input  wire logic             status_clear_in,     // clear stickies
  input  wire logic             dma_ready_in,        // drain accepts
  output logic                  dma_valid_out,       // word valid
  output logic [W-1:0]          dma_data_out,        // received word
  output logic                  flow_request_out,    // request to send
  output logic                  spi_overlength_out,  // sticky error
  output logic                  overrun_out,         // sticky drop
  output logic                  corrupt_out,         // sticky corrupt
  output logic                  rx_blocked_out,      // T1 receive lock
  output logic [`UQ_ERRCNT_W-1:0] iso_error_count_out // error count
);
  if (W < 3 || W > 15) begin : g_bad_width
    $error("character width must lie between 3 and 15");
  end
  function automatic logic tgl_evt(input logic a, input logic b);
    return a ^ b;
  endfunction

  // link domain
  logic [3:0]   len_s1_q;
  logic [3:0]   len_s2_q;
  logic [3:0]   bit_cnt_q;
  logic [W-2:0] shift_q;
  logic [W-1:0] word_q;
  logic         done_tgl_q;
  logic         ovl_tgl_q;
  logic         frame_rst;
  assign frame_rst = sys_rst_in | link_frame_n_in;
  always_ff @(posedge link_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      len_s1_q <= 4'h0;
      len_s2_q <= 4'h0;
    end else begin
      len_s1_q <= char_len_in;
      len_s2_q <= len_s1_q;
    end
  end
  // bit position ends with the frame's own select
  always_ff @(posedge link_clk_in or posedge frame_rst) begin
    if (frame_rst) begin
      bit_cnt_q <= 4'h0;
      shift_q   <= '0;
    end else begin
      shift_q <= {shift_q[W-3:0], link_data_in};
      if (bit_cnt_q != 4'hf) begin
        bit_cnt_q <= bit_cnt_q + 4'h1;
      end
    end
  end
  always_ff @(posedge link_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      word_q     <= '0;
      done_tgl_q <= 1'b0;
      ovl_tgl_q  <= 1'b0;
    end else if (!link_frame_n_in) begin
      if (bit_cnt_q + 4'h1 == len_s2_q) begin
        word_q     <= {shift_q, link_data_in};
        done_tgl_q <= ~done_tgl_q;
      end
      if (bit_cnt_q == len_s2_q && len_s2_q != 4'h0) begin
        ovl_tgl_q <= ~ovl_tgl_q; // R5
      end
    end
  end
  // system domain
  logic [2:0] done_sync_q;
  logic [2:0] ovl_sync_q;
  logic       done_evt;
  logic       ovl_evt;
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      done_sync_q <= 3'h0;
      ovl_sync_q  <= 3'h0;
    end else begin
      done_sync_q <= {done_sync_q[1:0], done_tgl_q};
      ovl_sync_q  <= {ovl_sync_q[1:0], ovl_tgl_q};
    end
  end

  assign done_evt = tgl_evt(done_sync_q[1], done_sync_q[2]);
  assign ovl_evt  = tgl_evt(ovl_sync_q[1], ovl_sync_q[2]);
  usart_quirks_pkg::serial_mode_e mode;
  usart_quirks_pkg::rx_state_e    rx_state_q;
  logic poison_q;
  logic push;
  logic fifo_ready;
  logic ovl_hit;
  assign mode    = usart_quirks_pkg::serial_mode_e'(serial_mode_in);
  assign ovl_hit = ovl_evt && mode == usart_quirks_pkg::MODE_SPI_SLAVE;
  // word_q is stable here because the link clock is slow enough // R4
  assign push = done_evt && rx_enable_in && !poison_q
             && rx_state_q == usart_quirks_pkg::RX_OPEN;
  // T1 turnaround lock
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rx_state_q <= usart_quirks_pkg::RX_OPEN;
    end else if (tx_done_in && mode == usart_quirks_pkg::MODE_ISO_T1) begin
      rx_state_q <= usart_quirks_pkg::RX_BLOCKED; // R8
    end else begin
      unique case (rx_state_q)
        usart_quirks_pkg::RX_OPEN: begin
          rx_state_q <= usart_quirks_pkg::RX_OPEN;
        end
        usart_quirks_pkg::RX_BLOCKED: begin
          if (rx_soft_reset_in) begin
            rx_state_q <= usart_quirks_pkg::RX_WAIT_MODE; // R8
          end
        end
        usart_quirks_pkg::RX_WAIT_MODE: begin
          if (mode_write_in) begin
            rx_state_q <= usart_quirks_pkg::RX_WAIT_CTRL; // R8
          end
        end
        usart_quirks_pkg::RX_WAIT_CTRL: begin
          if (control_write_in) begin
            rx_state_q <= usart_quirks_pkg::RX_OPEN; // R8
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rx_blocked_out <= 1'b0;
    end else begin
      rx_blocked_out <= (tx_done_in && mode == usart_quirks_pkg::MODE_ISO_T1)
        || (rx_state_q != usart_quirks_pkg::RX_OPEN
            && !(rx_state_q == usart_quirks_pkg::RX_WAIT_CTRL
                 && control_write_in));
    end
  end
  // overlength poison survives disable and soft reset
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      poison_q <= 1'b0;
    end else if (ovl_hit) begin
      poison_q <= 1'b1; // R6
    end else if (done_evt) begin
      poison_q <= 1'b0;
    end
  end
  // sticky status, set wins over clear
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      spi_overlength_out <= 1'b0;
      overrun_out        <= 1'b0;
      corrupt_out        <= 1'b0;
    end else begin
      spi_overlength_out <= ovl_hit
        || (spi_overlength_out && !status_clear_in); // R5
      overrun_out <= (push && !fifo_ready)
        || (overrun_out && !status_clear_in);
      corrupt_out <= (done_evt && poison_q)
        || (corrupt_out && !status_clear_in); // R6
    end
  end
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      iso_error_count_out <= `UQ_ERRCNT_RESET;
    end else begin
      iso_error_count_out <= `UQ_ERRCNT_RESET; // R7
    end
  end
  rx_fifo #(
    .W     (W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk_in        (sys_clk_in),
    .rst_in        (sys_rst_in),
    .in_valid_in   (push),
    .in_ready_out  (fifo_ready),
    .in_data_in    (word_q),
    .out_valid_out (dma_valid_out),
    .out_ready_in  (dma_ready_in),
    .out_data_out  (dma_data_out)
  );
  // request-to-send
  logic override_q;
  logic override_d;
  logic full_hs;
  assign full_hs = mode == usart_quirks_pkg::MODE_HANDSHAKE && !fifo_ready;
  always_comb begin
    override_d = override_q;
    if (flow_request_force_high_in) begin
      override_d = 1'b1; // R2
    end else if (flow_request_force_low_in) begin
      override_d = 1'b0; // R3
    end
  end
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      override_q       <= `UQ_FLOW_RESET;
      flow_request_out <= `UQ_FLOW_RESET;
    end else begin
      override_q       <= override_d;
      flow_request_out <= override_d | (FIX_RTS_FULL & full_hs); // R1
    end
  end

  // checks
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);
  force_high_a: assert property ( // R2
    flow_request_force_high_in |=> flow_request_out)
    else $error("request not high after force high");
  force_low_a: assert property ( // R3
    flow_request_force_low_in && !flow_request_force_high_in
    && !(FIX_RTS_FULL && full_hs) |=> !flow_request_out)
    else $error("request not low after force low");
  full_hold_a: assert property ( // R1
    full_hs && !override_d |=> flow_request_out == FIX_RTS_FULL)
    else $error("request wrong on full buffer");
  overlength_flag_a: assert property ( // R5
    ovl_hit |=> spi_overlength_out [*2])
    else $error("overlength not flagged");
  poison_set_a: assert property ( // R6
    ovl_hit |=> poison_q)
    else $error("overlength did not arm the poison");
  poison_drop_a: assert property ( // R6
    poison_q && done_evt |-> !push ##1 corrupt_out)
    else $error("frame after overlength not marked");
  err_count_a: assert property ( // R7
    iso_error_count_out == `UQ_ERRCNT_RESET)
    else $error("error count not zero");
  t1_lock_a: assert property ( // R8
    tx_done_in && mode == usart_quirks_pkg::MODE_ISO_T1
    |=> rx_blocked_out && !push)
    else $error("T1 receive not locked after transmit");
  t1_unlock_a: assert property ( // R8
    rx_state_q == usart_quirks_pkg::RX_BLOCKED && !rx_soft_reset_in
    && !(tx_done_in && mode == usart_quirks_pkg::MODE_ISO_T1)
    |=> rx_state_q == usart_quirks_pkg::RX_BLOCKED)
    else $error("T1 lock left without soft reset");
  overrun_a: assert property (
    push && !fifo_ready |=> overrun_out)
    else $error("overrun not flagged");
endmodule

// >>> usart_quirks_cfg.svh
// constants for the serial receiver with handshake and mode quirks
// assumes inclusion by bare name from the design file
`ifndef USART_QUIRKS_CFG_SVH
`define USART_QUIRKS_CFG_SVH

`define UQ_DATA_W        9
`define UQ_FIFO_DEPTH    16
`define UQ_LEN_W         4
`define UQ_ERRCNT_W      8
`define UQ_ERRCNT_RESET  8'h00
`define UQ_LINK_RATIO    9
`define UQ_FLOW_RESET    1'b0
`define UQ_FIX_RTS_FULL  1'b0

`endif

// >>> usart_quirks_pkg.sv
// types for the serial receiver with handshake and mode quirks
// assumes usart_quirks_cfg.svh is on the include path
package usart_quirks_pkg;
  typedef enum logic [1:0] {
    MODE_NORMAL    = 2'b00,
    MODE_HANDSHAKE = 2'b01,
    MODE_SPI_SLAVE = 2'b10,
    MODE_ISO_T1    = 2'b11
  } serial_mode_e;

  typedef enum logic [1:0] {
    RX_OPEN      = 2'b00,
    RX_BLOCKED   = 2'b01,
    RX_WAIT_MODE = 2'b10,
    RX_WAIT_CTRL = 2'b11
  } rx_state_e;
endpackage
